/* src/bbf_exec.v */
// execute logic for branches on V and I, I/O bit set/clear, shifts,
// bit transfer, single flag set/clear and register moves
// assumes one core clock, an instruction source that honours
// ins_ready_o, and an I/O space that acts on io_set_o / io_clr_o pulses
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "bbf_exec_map.vh"

module bbf_exec (
  input wire ref_clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire ins_valid_i,
  input wire [4:0] ins_op_i,
  input wire [4:0] ins_rd_i,
  input wire [4:0] ins_rr_i,
  input wire [2:0] ins_bit_i,
  input wire [7:0] ins_imm_i,
  input wire [6:0] ins_ofs_i,
  input wire [5:0] bus_addr_i,
  input wire [7:0] bus_wdata_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  output reg [7:0] bus_rdata_o,
  output reg ins_ready_o,
  output reg ins_done_o,
  output reg [15:0] pc_o,
  output reg [7:0] status_o,
  output reg [4:0] io_addr_o,
  output reg [2:0] io_bit_o,
  output reg io_set_o,
  output reg io_clr_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;
  localparam NUM_GPR = 32;

  // working register file, kept in flip-flops
  reg [7:0] gpr [0:NUM_GPR-1];
  reg state;
  reg hold_io;

  reg next_state;
  reg next_hold_io;
  reg next_ready;
  reg next_done;
  reg [15:0] next_pc;
  reg [7:0] next_status;
  reg [4:0] next_io_addr;
  reg [2:0] next_io_bit;
  reg next_io_set;
  reg next_io_clr;
  reg gw_en;
  reg gw_pair;
  reg [4:0] gw_idx;
  reg [7:0] gw_data;
  reg [7:0] gw_data_hi;

  wire accept;
  wire [7:0] rd_val;
  wire [7:0] rr_val;
  wire [4:0] pair_dst;
  wire [4:0] pair_src;
  wire [15:0] br_target;
  wire [7:0] sh_dout;
  wire sh_c;
  wire sh_z;
  wire sh_n;
  wire sh_v;
  integer i;

  // bus offset decode, shared by the write and the read path
  function is_gpr;
    input [5:0] addr;
    begin
      is_gpr = ((addr & `BBF_ADDR_GPR_BASE) == `BBF_ADDR_GPR_BASE);
    end
  endfunction

  // replace one bit of a byte
  function [7:0] put_bit;
    input [7:0] val;
    input [2:0] pos;
    input b;
    reg [7:0] mask;
    begin
      mask = 8'h01 << pos;
      put_bit = b ? (val | mask) : (val & ~mask);
    end
  endfunction

  assign accept = ins_valid_i & ins_ready_o;
  assign rd_val = gpr[ins_rd_i];
  assign rr_val = gpr[ins_rr_i];
  // pair copy works on aligned even/odd registers only
  assign pair_dst = {ins_rd_i[4:1], 1'b0};
  assign pair_src = {ins_rr_i[4:1], 1'b0};
  // target is pc plus sign-extended offset plus one
  assign br_target = pc_o + {{9{ins_ofs_i[6]}}, ins_ofs_i} + 16'h0001;

  bbf_shift u_shift (
    .op_i(ins_op_i),
    .din_i(rd_val),
    .cin_i(status_o[`BBF_STAT_C]),
    .dout_o(sh_dout),
    .c_o(sh_c),
    .z_o(sh_z),
    .n_o(sh_n),
    .v_o(sh_v)
  );

  // next-state decode; an instruction in the same cycle as a bus write
  // to status or pc wins on the bits it touches, so no flag event is lost
  always @* begin
    next_state = state;
    next_hold_io = hold_io;
    next_ready = ins_ready_o;
    next_done = 1'b0;
    next_pc = (bus_wr_i && bus_addr_i == `BBF_ADDR_PC_LO) ?
              {pc_o[15:8], bus_wdata_i} :
              (bus_wr_i && bus_addr_i == `BBF_ADDR_PC_HI) ?
              {bus_wdata_i, pc_o[7:0]} : pc_o;
    next_status = (bus_wr_i && bus_addr_i == `BBF_ADDR_STATUS) ? bus_wdata_i : status_o;
    next_io_addr = io_addr_o;
    next_io_bit = io_bit_o;
    next_io_set = 1'b0;
    next_io_clr = 1'b0;
    gw_en = 1'b0;
    gw_pair = 1'b0;
    gw_idx = ins_rd_i;
    gw_data = rd_val;
    gw_data_hi = 8'h00;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_pc = pc_o + 16'h0001;
          next_done = 1'b1;
          case (ins_op_i)
            `BBF_OP_BRANCH_ON_OVERFLOW_CLEAR: begin
              if (!status_o[`BBF_STAT_V]) begin
                next_pc = br_target;
                next_state = ST_HOLD;
                next_hold_io = 1'b0;
                next_ready = 1'b0;
                next_done = 1'b0;
              end
            end
            `BBF_OP_BRANCH_IF_INT_ENABLED: begin
              if (status_o[`BBF_STAT_I]) begin
                next_pc = br_target;
                next_state = ST_HOLD;
                next_hold_io = 1'b0;
                next_ready = 1'b0;
                next_done = 1'b0;
              end
            end
            `BBF_OP_BRANCH_IF_INT_DISABLED: begin
              if (!status_o[`BBF_STAT_I]) begin
                next_pc = br_target; // flags left alone
                next_state = ST_HOLD;
                next_hold_io = 1'b0;
                next_ready = 1'b0;
                next_done = 1'b0;
              end
            end
            `BBF_OP_SET_IO_BIT: begin
              // second cycle issues the set, matching the slower timing
              next_io_addr = ins_rd_i;
              next_io_bit = ins_bit_i;
              next_state = ST_HOLD;
              next_hold_io = 1'b1;
              next_ready = 1'b0;
              next_done = 1'b0;
            end
            `BBF_OP_CLEAR_IO_BIT: begin
              next_io_addr = ins_rd_i;
              next_io_bit = ins_bit_i;
              next_io_clr = 1'b1;
            end
            `BBF_OP_SHIFT_LEFT_LOGICAL,
            `BBF_OP_SHIFT_RIGHT_LOGICAL,
            `BBF_OP_ROTATE_LEFT_CARRY,
            `BBF_OP_ROTATE_RIGHT_CARRY,
            `BBF_OP_SHIFT_RIGHT_ARITH: begin
              gw_en = 1'b1;
              gw_data = sh_dout;
              next_status[`BBF_STAT_Z] = sh_z;
              next_status[`BBF_STAT_C] = sh_c;
              next_status[`BBF_STAT_N] = sh_n;
              next_status[`BBF_STAT_V] = sh_v;
            end
            `BBF_OP_BIT_STORE_TO_TRANSFER: begin
              next_status[`BBF_STAT_T] = rr_val[ins_bit_i];
            end
            `BBF_OP_BIT_LOAD_FROM_TRANSFER: begin
              gw_en = 1'b1;
              gw_data = put_bit(rd_val, ins_bit_i, status_o[`BBF_STAT_T]);
            end
            `BBF_OP_SET_OVERFLOW_FLAG: next_status[`BBF_STAT_V] = 1'b1;
            `BBF_OP_CLEAR_OVERFLOW_FLAG: next_status[`BBF_STAT_V] = 1'b0;
            `BBF_OP_SET_HALF_CARRY: next_status[`BBF_STAT_H] = 1'b1;
            `BBF_OP_CLEAR_HALF_CARRY: next_status[`BBF_STAT_H] = 1'b0;
            `BBF_OP_SET_SIGNED_FLAG: next_status[`BBF_STAT_S] = 1'b1;
            `BBF_OP_CLEAR_SIGNED_FLAG: next_status[`BBF_STAT_S] = 1'b0;
            `BBF_OP_SET_NEGATIVE_FLAG: next_status[`BBF_STAT_N] = 1'b1;
            `BBF_OP_CLEAR_NEGATIVE_FLAG: next_status[`BBF_STAT_N] = 1'b0;
            `BBF_OP_SET_ZERO_FLAG: next_status[`BBF_STAT_Z] = 1'b1;
            `BBF_OP_CLEAR_ZERO_FLAG: next_status[`BBF_STAT_Z] = 1'b0;
            `BBF_OP_REGISTER_COPY: begin
              gw_en = 1'b1;
              gw_data = rr_val;
            end
            `BBF_OP_REGISTER_PAIR_COPY: begin
              gw_en = 1'b1;
              gw_pair = 1'b1;
              gw_idx = pair_dst;
              gw_data = gpr[pair_src]; // both bytes in one write
              gw_data_hi = gpr[pair_src | 5'h01];
            end
            `BBF_OP_LOAD_IMMEDIATE: begin
              gw_en = 1'b1;
              gw_data = ins_imm_i;
            end
            default: begin
              // unknown codes behave as a one-cycle no-op
              next_done = 1'b1;
            end
          endcase
        end
      end
      ST_HOLD: begin
        next_state = ST_IDLE;
        next_ready = 1'b1;
        next_done = 1'b1;
        next_io_set = hold_io;
        next_hold_io = 1'b0;
      end
      default: begin
        next_state = ST_IDLE;
        next_ready = 1'b1;
        next_hold_io = 1'b0;
      end
    endcase
  end

  // control state and outputs; ce_i low freezes everything
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      hold_io <= 1'b0;
      ins_ready_o <= 1'b1;
      ins_done_o <= 1'b0;
      pc_o <= `BBF_PC_RST;
      status_o <= `BBF_STAT_RST;
      io_addr_o <= 5'h00;
      io_bit_o <= 3'h0;
      io_set_o <= 1'b0;
      io_clr_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      hold_io <= next_hold_io;
      ins_ready_o <= next_ready;
      ins_done_o <= next_done;
      pc_o <= next_pc;
      status_o <= next_status;
      io_addr_o <= next_io_addr;
      io_bit_o <= next_io_bit;
      io_set_o <= next_io_set;
      io_clr_o <= next_io_clr;
    end
  end

  // register file: bus writes first, instruction writes override
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (i = 0; i < NUM_GPR; i = i + 1) begin
        gpr[i] <= `BBF_GPR_RST;
      end
    end else if (ce_i) begin
      if (bus_wr_i && is_gpr(bus_addr_i)) begin
        gpr[bus_addr_i[4:0]] <= bus_wdata_i;
      end
      if (gw_en) begin
        gpr[gw_idx] <= gw_data;
        if (gw_pair) begin
          gpr[gw_idx | 5'h01] <= gw_data_hi;
        end
      end
    end
  end

  // read data for one cycle after the strobe, zero otherwise;
  // unmapped offsets read as zero
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      bus_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (bus_rd_i) begin
        if (is_gpr(bus_addr_i)) begin
          bus_rdata_o <= gpr[bus_addr_i[4:0]];
        end else if (bus_addr_i == `BBF_ADDR_STATUS) begin
          bus_rdata_o <= status_o;
        end else if (bus_addr_i == `BBF_ADDR_PC_LO) begin
          bus_rdata_o <= pc_o[7:0];
        end else if (bus_addr_i == `BBF_ADDR_PC_HI) begin
          bus_rdata_o <= pc_o[15:8];
        end else begin
          bus_rdata_o <= 8'h00;
        end
      end else begin
        bus_rdata_o <= 8'h00;
      end
    end
  end

endmodule // bbf_exec
`default_nettype wire

/* inc/bbf_exec_map.vh */
// constants of the branch, bit and flag execute block
// assumes inclusion by bare name from the design sources
// Function
// - branch_on_overflow_clear jumps to pc plus offset plus one when V is 0, one cycle if not taken and two if taken.
// - branch_if_int_enabled jumps to pc plus offset plus one only when I is 1, taking one or two cycles.
// - branch_if_int_disabled jumps to pc plus offset plus one only when I is 0, changes no flag and takes one or two cycles.
// - set_io_bit forces the addressed bit of the selected I/O register to one, touches no flag and takes two cycles.
// - clear_io_bit forces the addressed bit of the selected I/O register to zero, touches no flag and takes one cycle.
// - shift_left_logical and shift_right_logical move bits one place with a zero fill and update Z, C, N and V in one cycle.
// - rotate_left_carry shifts up with old C into bit 0, loads C from old bit 7 and updates Z, C, N, V in one cycle.
// - rotate_right_carry shifts down with old C into bit 7, loads C from old bit 0 and updates Z, C, N, V in one cycle.
// - bit_store_to_transfer copies a chosen register bit into T, changing only T, in one cycle.
// - bit_load_from_transfer writes T into a chosen register bit, changing no flag, in one cycle.
// - set_overflow_flag and clear_overflow_flag each change only V in one cycle.
// - set_half_carry and clear_half_carry each change only H in one cycle.
// - set_signed_flag and clear_signed_flag each change only S in one cycle.
// - set and clear of N and of Z each change only their own flag in one cycle.
`ifndef BBF_EXEC_MAP_VH
`define BBF_EXEC_MAP_VH

// status register bit positions
`define BBF_STAT_C 0
`define BBF_STAT_Z 1
`define BBF_STAT_N 2
`define BBF_STAT_V 3
`define BBF_STAT_S 4
`define BBF_STAT_H 5
`define BBF_STAT_T 6
`define BBF_STAT_I 7

// reset values
`define BBF_STAT_RST 8'h00
`define BBF_PC_RST 16'h0000
`define BBF_GPR_RST 8'h00

// register port offsets
`define BBF_ADDR_STATUS 6'h00
`define BBF_ADDR_PC_LO 6'h01
`define BBF_ADDR_PC_HI 6'h02
`define BBF_ADDR_GPR_BASE 6'h20

// operation codes on the instruction port
`define BBF_OP_NONE 5'h00
`define BBF_OP_BRANCH_ON_OVERFLOW_CLEAR 5'h01
`define BBF_OP_BRANCH_IF_INT_ENABLED 5'h02
`define BBF_OP_BRANCH_IF_INT_DISABLED 5'h03
`define BBF_OP_SET_IO_BIT 5'h04
`define BBF_OP_CLEAR_IO_BIT 5'h05
`define BBF_OP_SHIFT_LEFT_LOGICAL 5'h06
`define BBF_OP_SHIFT_RIGHT_LOGICAL 5'h07
`define BBF_OP_ROTATE_LEFT_CARRY 5'h08
`define BBF_OP_ROTATE_RIGHT_CARRY 5'h09
`define BBF_OP_SHIFT_RIGHT_ARITH 5'h0A
`define BBF_OP_BIT_STORE_TO_TRANSFER 5'h0B
`define BBF_OP_BIT_LOAD_FROM_TRANSFER 5'h0C
`define BBF_OP_SET_OVERFLOW_FLAG 5'h0D
`define BBF_OP_CLEAR_OVERFLOW_FLAG 5'h0E
`define BBF_OP_SET_HALF_CARRY 5'h0F
`define BBF_OP_CLEAR_HALF_CARRY 5'h10
`define BBF_OP_SET_SIGNED_FLAG 5'h11
`define BBF_OP_CLEAR_SIGNED_FLAG 5'h12
`define BBF_OP_SET_NEGATIVE_FLAG 5'h13
`define BBF_OP_CLEAR_NEGATIVE_FLAG 5'h14
`define BBF_OP_SET_ZERO_FLAG 5'h15
`define BBF_OP_CLEAR_ZERO_FLAG 5'h16
`define BBF_OP_REGISTER_COPY 5'h17
`define BBF_OP_REGISTER_PAIR_COPY 5'h18
`define BBF_OP_LOAD_IMMEDIATE 5'h19

`endif

/* src/bbf_shift.v */
// shift and rotate unit of the execute block, purely combinational
// assumes the caller registers the result and the flags
`timescale 1ns/10ps
`default_nettype none
`include "bbf_exec_map.vh"

module bbf_shift (
  input wire [4:0] op_i,
  input wire [7:0] din_i,
  input wire cin_i,
  output reg [7:0] dout_o,
  output reg c_o,
  output reg z_o,
  output reg n_o,
  output reg v_o
);

  // overflow after a shift is taken as N xor C, the usual choice for this class
  always @* begin
    dout_o = din_i;
    c_o = cin_i;
    case (op_i)
      `BBF_OP_SHIFT_LEFT_LOGICAL: begin
        dout_o = {din_i[6:0], 1'b0};
        c_o = din_i[7];
      end
      `BBF_OP_SHIFT_RIGHT_LOGICAL: begin
        dout_o = {1'b0, din_i[7:1]};
        c_o = din_i[0];
      end
      `BBF_OP_ROTATE_LEFT_CARRY: begin
        dout_o = {din_i[6:0], cin_i};
        c_o = din_i[7];
      end
      `BBF_OP_ROTATE_RIGHT_CARRY: begin
        dout_o = {cin_i, din_i[7:1]};
        c_o = din_i[0];
      end
      `BBF_OP_SHIFT_RIGHT_ARITH: begin
        dout_o = {din_i[7], din_i[7:1]}; // sign kept
        c_o = din_i[0];
      end
      default: begin
        dout_o = din_i;
        c_o = cin_i;
      end
    endcase
    z_o = (dout_o == 8'h00);
    n_o = dout_o[7];
    v_o = dout_o[7] ^ c_o;
  end

endmodule // bbf_shift
`default_nettype wire

/* verif/bbf_exec_checker.sv */
// port assertions for bbf_exec, bound after the module
// assumes one clock domain and ce_i held high by the bench
`timescale 1ns/10ps
`default_nettype none
`include "bbf_exec_map.vh"
module bbf_exec_checker (
  input wire ref_clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire ins_valid_i,
  input wire [4:0] ins_op_i,
  input wire [4:0] ins_rd_i,
  input wire [4:0] ins_rr_i,
  input wire [2:0] ins_bit_i,
  input wire [7:0] ins_imm_i,
  input wire [6:0] ins_ofs_i,
  input wire [5:0] bus_addr_i,
  input wire [7:0] bus_wdata_i,
  input wire bus_wr_i,
  input wire bus_rd_i,
  input wire [7:0] bus_rdata_o,
  input wire ins_ready_o,
  input wire ins_done_o,
  input wire [15:0] pc_o,
  input wire [7:0] status_o,
  input wire [4:0] io_addr_o,
  input wire [2:0] io_bit_o,
  input wire io_set_o,
  input wire io_clr_o
);
  logic take;
  logic [15:0] tgt;
  logic [7:0] fmask;
  logic [7:0] fexp;
  logic vf;
  logic itf;
  // taken request, branch target and single-flag expectation
  assign take = ins_valid_i && ins_ready_o && ce_i;
  assign tgt = pc_o + {{9{ins_ofs_i[6]}}, ins_ofs_i} + 16'h0001;
  assign vf = status_o[`BBF_STAT_V];
  assign itf = status_o[`BBF_STAT_I];
  assign fexp = ins_op_i[0] ? (status_o | fmask) : (status_o & ~fmask);
  // set/clear codes come in pairs, so (op-1)/2 picks the flag
  always_comb begin
    case ((ins_op_i - 5'h01) >> 1)
      5'h06: fmask = 8'h08;
      5'h07: fmask = 8'h20;
      5'h08: fmask = 8'h10;
      5'h09: fmask = 8'h04;
      5'h0A: fmask = 8'h02;
      default: fmask = 8'h00;
    endcase
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // busy cycle then completion
  sequence s_two;
    !ins_ready_o && !ins_done_o ##1 ins_ready_o && ins_done_o;
  endsequence
  AST_OVF_CLR_TAKEN: assert property (take && ins_op_i == `BBF_OP_BRANCH_ON_OVERFLOW_CLEAR && !vf
    |=> (pc_o == $past(tgt)) ##0 s_two) else $error("overflow-clear branch wrong");
  AST_INT_EN_TAKEN: assert property (take && ins_op_i == `BBF_OP_BRANCH_IF_INT_ENABLED && itf
    |=> (pc_o == $past(tgt)) ##0 s_two) else $error("int-enabled branch wrong");
  AST_INT_DIS_TAKEN: assert property (take && ins_op_i == `BBF_OP_BRANCH_IF_INT_DISABLED && !itf
    && !bus_wr_i |=> (pc_o == $past(tgt) && status_o == $past(status_o)) ##0 s_two)
    else $error("int-disabled branch wrong");
  AST_BR_NOT_TAKEN: assert property (take && ((ins_op_i == `BBF_OP_BRANCH_ON_OVERFLOW_CLEAR
    && vf) || (ins_op_i == `BBF_OP_BRANCH_IF_INT_ENABLED && !itf)
    || (ins_op_i == `BBF_OP_BRANCH_IF_INT_DISABLED && itf))
    |=> pc_o == $past(pc_o) + 16'h0001 && ins_done_o && ins_ready_o) else $error("untaken branch");
  AST_SET_IO: assert property (take && ins_op_i == `BBF_OP_SET_IO_BIT |=>
    (io_addr_o == $past(ins_rd_i) && io_bit_o == $past(ins_bit_i) && !io_set_o) ##0 s_two
    ##0 io_set_o) else $error("set io bit wrong");
  AST_CLR_IO: assert property (take && ins_op_i == `BBF_OP_CLEAR_IO_BIT |=> io_clr_o
    && ins_done_o && io_addr_o == $past(ins_rd_i) && io_bit_o == $past(ins_bit_i) && !io_set_o)
    else $error("clear io bit wrong");
  AST_FLAG_ONE: assert property (take && !bus_wr_i && ins_op_i inside
    {[`BBF_OP_SET_OVERFLOW_FLAG:`BBF_OP_CLEAR_ZERO_FLAG]} |=> status_o == $past(fexp)
    && ins_done_o) else $error("flag op touched other flags");
  AST_TSTORE_ONLY_T: assert property (take && !bus_wr_i && ins_op_i == `BBF_OP_BIT_STORE_TO_TRANSFER
    |=> (status_o & 8'hBF) == ($past(status_o) & 8'hBF) && ins_done_o) else $error("bit store flags");
  AST_RDATA_IDLE: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 8'h00)
    else $error("read data outside read cycle");
endmodule // bbf_exec_checker
bind bbf_exec bbf_exec_checker u_chk (.ref_clk_i, .srst_i, .ce_i, .ins_valid_i, .ins_op_i,
  .ins_rd_i, .ins_rr_i, .ins_bit_i, .ins_imm_i, .ins_ofs_i, .bus_addr_i, .bus_wdata_i,
  .bus_wr_i, .bus_rd_i, .bus_rdata_o, .ins_ready_o, .ins_done_o, .pc_o, .status_o,
  .io_addr_o, .io_bit_o, .io_set_o, .io_clr_o);
`default_nettype wire

/* verif/bbf_exec_tb.sv */
// self-checking bench for bbf_exec over its instruction and register ports
// assumes bbf_exec_map.vh on the include path; ce_i is held high
`timescale 1ns/10ps
`default_nettype none
`include "bbf_exec_map.vh"
module bbf_exec_tb;
  logic ref_clk_i, srst_i, ins_valid_i, bus_wr_i, bus_rd_i, ins_ready_o, ins_done_o;
  logic io_set_o, io_clr_o;
  logic [4:0] ins_op_i, ins_rd_i, ins_rr_i, io_addr_o;
  logic [2:0] ins_bit_i, io_bit_o;
  logic [7:0] ins_imm_i, bus_wdata_i, bus_rdata_o, status_o;
  logic [6:0] ins_ofs_i;
  logic [5:0] bus_addr_i;
  logic [15:0] pc_o;
  int mismatches = 0;
  int n_compared = 0;
  bbf_exec uut (.ref_clk_i, .srst_i, .ce_i(1'b1), .ins_valid_i, .ins_op_i, .ins_rd_i,
    .ins_rr_i, .ins_bit_i, .ins_imm_i, .ins_ofs_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i,
    .bus_rd_i, .bus_rdata_o, .ins_ready_o, .ins_done_o, .pc_o, .status_o, .io_addr_o,
    .io_bit_o, .io_set_o, .io_clr_o);
  // 100 MHz core clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one-cycle strobes, read data looked at in the cycle after only
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge ref_clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge ref_clk_i);
    bus_rd_i <= 1'b0;
    #1;
    chk(bus_rdata_o, e);
  endtask
  task automatic pcchk(input logic [15:0] e);
    rd(`BBF_ADDR_PC_LO, e[7:0]);
    rd(`BBF_ADDR_PC_HI, e[15:8]);
  endtask
  // issue one instruction; v is both immediate and offset; n is the expected cycle count
  task automatic ex(input logic [4:0] op, d, r, input logic [2:0] b, input logic [7:0] v,
                    input int n);
    int c;
    @(posedge ref_clk_i);
    ins_valid_i <= 1'b1;
    ins_op_i <= op;
    ins_rd_i <= d;
    ins_rr_i <= r;
    ins_bit_i <= b;
    ins_imm_i <= v;
    ins_ofs_i <= v[6:0];
    @(posedge ref_clk_i);
    ins_valid_i <= 1'b0;
    c = 1;
    #1;
    while (ins_done_o !== 1'b1 && c < 8) begin
      @(posedge ref_clk_i);
      #1;
      c++;
    end
    chk(16'(c), 16'(n));
  endtask
  task automatic t_reset();
    rd(`BBF_ADDR_STATUS, `BBF_STAT_RST);
    pcchk(`BBF_PC_RST);
    rd(6'h3F, `BBF_GPR_RST);
    wr(6'h03, 8'hAA);
    rd(6'h03, 8'h00);
  endtask
  task automatic t_branch();
    wr(`BBF_ADDR_PC_LO, 8'h10);
    wr(`BBF_ADDR_STATUS, 8'h00);
    ex(`BBF_OP_BRANCH_ON_OVERFLOW_CLEAR, 0, 0, 0, 8'h03, 2);
    pcchk(16'h0014);
    ex(`BBF_OP_SET_OVERFLOW_FLAG, 0, 0, 0, 8'h00, 1);
    ex(`BBF_OP_BRANCH_ON_OVERFLOW_CLEAR, 0, 0, 0, 8'h03, 1);
    wr(`BBF_ADDR_STATUS, 8'h80);
    ex(`BBF_OP_BRANCH_IF_INT_ENABLED, 0, 0, 0, 8'h7F, 2);
    ex(`BBF_OP_BRANCH_IF_INT_DISABLED, 0, 0, 0, 8'h05, 1);
    rd(`BBF_ADDR_STATUS, 8'h80);
    wr(`BBF_ADDR_STATUS, 8'h00);
    ex(`BBF_OP_BRANCH_IF_INT_ENABLED, 0, 0, 0, 8'h05, 1);
    ex(`BBF_OP_BRANCH_IF_INT_DISABLED, 0, 0, 0, 8'h40, 2);
    pcchk(16'hFFD9);
    rd(`BBF_ADDR_STATUS, 8'h00);
  endtask
  task automatic t_io();
    wr(`BBF_ADDR_STATUS, 8'h55);
    ex(`BBF_OP_SET_IO_BIT, 5'h1F, 0, 3'h7, 8'h00, 2);
    chk(io_set_o, 1'b1);
    chk({io_addr_o, io_bit_o}, {5'h1F, 3'h7});
    ex(`BBF_OP_CLEAR_IO_BIT, 5'h01, 0, 3'h0, 8'h00, 1);
    chk({io_clr_o, io_addr_o, io_bit_o}, {1'b1, 5'h01, 3'h0});
    rd(`BBF_ADDR_STATUS, 8'h55);
  endtask
  // r16 in, status preset with S and H set to show they are untouched
  task automatic sh(input logic [4:0] op, input logic [7:0] d, input logic ci,
                    input logic [7:0] q, f);
    wr(6'h30, d);
    wr(`BBF_ADDR_STATUS, {7'h18, ci});
    ex(op, 5'd16, 0, 0, 8'h00, 1);
    rd(6'h30, q);
    rd(`BBF_ADDR_STATUS, f | 8'h30);
  endtask
  task automatic t_shift();
    sh(`BBF_OP_SHIFT_LEFT_LOGICAL, 8'h81, 1'b0, 8'h02, 8'h09);
    sh(`BBF_OP_SHIFT_LEFT_LOGICAL, 8'h00, 1'b0, 8'h00, 8'h02);
    sh(`BBF_OP_SHIFT_RIGHT_LOGICAL, 8'h81, 1'b1, 8'h40, 8'h09);
    sh(`BBF_OP_ROTATE_LEFT_CARRY, 8'h40, 1'b1, 8'h81, 8'h0C);
    sh(`BBF_OP_ROTATE_RIGHT_CARRY, 8'h01, 1'b0, 8'h00, 8'h0B);
    sh(`BBF_OP_ROTATE_RIGHT_CARRY, 8'h00, 1'b1, 8'h80, 8'h0C);
    sh(`BBF_OP_SHIFT_RIGHT_ARITH, 8'h81, 1'b0, 8'hC0, 8'h05);
  endtask
  task automatic t_bits();
    wr(6'h25, 8'h08);
    wr(`BBF_ADDR_STATUS, 8'h00);
    ex(`BBF_OP_BIT_STORE_TO_TRANSFER, 0, 5'd5, 3'd3, 8'h00, 1);
    rd(`BBF_ADDR_STATUS, 8'h40);
    ex(`BBF_OP_BIT_LOAD_FROM_TRANSFER, 5'd6, 0, 3'd0, 8'h00, 1);
    rd(6'h26, 8'h01);
    rd(`BBF_ADDR_STATUS, 8'h40);
    ex(`BBF_OP_BIT_STORE_TO_TRANSFER, 0, 5'd5, 3'd2, 8'h00, 1);
    rd(`BBF_ADDR_STATUS, 8'h00);
  endtask
  // odd codes set from all-clear, even codes clear from all-set
  task automatic t_flags();
    logic [7:0] m [5] = '{8'h08, 8'h20, 8'h10, 8'h04, 8'h02};
    logic [4:0] op;
    for (int i = 0; i < 10; i++) begin
      op = `BBF_OP_SET_OVERFLOW_FLAG + 5'(i);
      wr(`BBF_ADDR_STATUS, op[0] ? 8'h00 : 8'hFF);
      ex(op, 0, 0, 0, 8'h00, 1);
      rd(`BBF_ADDR_STATUS, op[0] ? m[i / 2] : ~m[i / 2]);
    end
  endtask
  task automatic t_move();
    wr(`BBF_ADDR_STATUS, 8'h3F);
    ex(`BBF_OP_LOAD_IMMEDIATE, 5'd20, 0, 0, 8'hA5, 1);
    ex(`BBF_OP_LOAD_IMMEDIATE, 5'd21, 0, 0, 8'h5A, 1);
    ex(`BBF_OP_REGISTER_COPY, 5'd7, 5'd20, 0, 8'h00, 1);
    ex(`BBF_OP_REGISTER_PAIR_COPY, 5'd2, 5'd20, 0, 8'h00, 1);
    ex(5'h1F, 0, 0, 0, 8'h00, 1);
    rd(6'h27, 8'hA5);
    rd(6'h22, 8'hA5);
    rd(6'h23, 8'h5A);
    rd(`BBF_ADDR_STATUS, 8'h3F);
  endtask
  // all inputs quiet at time zero, reset for 8 cycles
  initial begin
    srst_i = 1'b1;
    {ins_valid_i, bus_wr_i, bus_rd_i, bus_addr_i, bus_wdata_i} = '0;
    {ins_op_i, ins_rd_i, ins_rr_i, ins_bit_i, ins_imm_i, ins_ofs_i} = '0;
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_reset();
    $display("reset test done");
    t_branch();
    $display("branch test done");
    t_io();
    $display("io bit test done");
    t_shift();
    $display("shift test done");
    t_bits();
    $display("bit transfer test done");
    t_flags();
    $display("flag test done");
    t_move();
    $display("move test done");
    end_sim();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule // bbf_exec_tb
`default_nettype wire
